// >>> uaf_pkg.sv
// package: register map, reset values, field positions and state codes
package uaf_pkg;
  // register offsets
  localparam logic [7:0] SCTL_OFS  = 8'h98;
  localparam logic [7:0] RBUF_OFS  = 8'h99;
  localparam logic [7:0] PCTL_OFS  = 8'h87;
  localparam logic [7:0] SADR_OFS  = 8'hA9;
  localparam logic [7:0] SMSK_OFS  = 8'hB9;
  localparam logic [7:0] ISTAT_OFS = 8'hC0;
  localparam logic [7:0] IMASK_OFS = 8'hC1;
  localparam logic [7:0] BAUD_OFS  = 8'hC2;
  // reset values
  localparam logic [7:0] SCTL_RST  = 8'h00;
  localparam logic [7:0] PCTL_RST  = 8'h00;
  localparam logic [7:0] SADR_RST  = 8'h00;
  localparam logic [7:0] SMSK_RST  = 8'h00;
  localparam logic [7:0] BAUD_RST  = 8'h0F;
  localparam logic [1:0] IRQ_RST   = 2'h0;
  // serial control fields
  localparam int SCTL_MODE0_BIT = 7;
  localparam int SCTL_MODE1_BIT = 6;
  localparam int SCTL_CMP_BIT   = 5;
  localparam int SCTL_REN_BIT   = 4;
  localparam int SCTL_TB8_BIT   = 3;
  localparam int SCTL_RB8_BIT   = 2;
  localparam int SCTL_TI_BIT    = 1;
  localparam int SCTL_RI_BIT    = 0;
  // power control field
  localparam int PCTL_FSEL_BIT  = 6;
  // interrupt status fields
  localparam int IRQ_RX_BIT     = 0;
  localparam int IRQ_FE_BIT     = 1;
  // serial modes
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_8BIT  = 2'h1;
  // oversampling: ticks per bit and the mid-bit sample point; frame bit counts
  localparam logic [3:0] OVS_LAST   = 4'hF;
  localparam logic [3:0] OVS_MID    = 4'h7;
  localparam logic [3:0] BITS_8     = 4'h8;
  localparam logic [3:0] BITS_9     = 4'h9;
  // receiver states
  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } uaf_rx_state_t;
endpackage

// >>> uaf_rx_if.sv
// interface: received frame handed from the deserialiser to the core
`timescale 1ns/1ps
interface uaf_rx_if;
  logic [8:0] data;
  logic       stop_ok;
  logic       done;
  logic       shift_clk;
  modport frame (output data, output stop_ok, output done, output shift_clk);
  modport core  (input data, input stop_ok, input done, input shift_clk);
endinterface

// >>> uaf_addr_match.sv
// address matcher: given and broadcast comparison of one received byte
`timescale 1ns/1ps
module uaf_addr_match (
  // compare inputs
  input  wire logic [7:0] rx_byte,
  input  wire logic [7:0] slave_address,
  input  wire logic [7:0] slave_address_mask,
  // result
  output logic            match
);
  // one where the byte has every required one bit
  function automatic logic covers(input logic [7:0] b, input logic [7:0] need);
    covers = ((b & need) == need);
  endfunction
  logic given_hit;
  logic bcast_hit;
  // masked bits compare, unmasked are don't-care
  assign given_hit = ((rx_byte ^ slave_address) & slave_address_mask) == 8'h00; // R9
  // broadcast: ones of the or must be ones in the byte
  assign bcast_hit = covers(rx_byte, slave_address | slave_address_mask); // R10
  assign match     = given_hit | bcast_hit;
endmodule

// >>> uaf_rx_frame.sv
// deserialiser: start detect, mid-bit sampling, stop check, shift mode
`timescale 1ns/1ps
module uaf_rx_frame (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // control
  input  wire logic       rx_pin,
  input  wire logic       tick,
  input  wire logic       enable,
  input  wire logic [1:0] mode,
  // frame out
  uaf_rx_if.frame         rxo
);
  logic                  meta_reg;
  logic                  sync_reg;
  uaf_pkg::uaf_rx_state_t state_reg;
  logic [3:0]            tick_cnt_reg;
  logic [3:0]            bit_cnt_reg;
  logic [8:0]            shift_reg;
  logic [3:0]            nbits;
  logic                  is_shift;
  assign is_shift = (mode == uaf_pkg::MODE_SHIFT);
  assign nbits    = (mode == uaf_pkg::MODE_8BIT || is_shift) ? uaf_pkg::BITS_8 : uaf_pkg::BITS_9;
  // two-stage synchroniser for the pin
  always_ff @(posedge core_clk) begin
    meta_reg <= rx_pin;
    sync_reg <= meta_reg;
  end
  // frame sequencer; shift mode clocks one bit per two ticks
  always_ff @(posedge core_clk) begin
    rxo.done <= 1'b0;
    if (rst || !enable) begin
      state_reg     <= uaf_pkg::RX_IDLE;
      tick_cnt_reg  <= 4'h0;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 9'h000;
      rxo.data      <= 9'h000;
      rxo.stop_ok   <= 1'b0;
      rxo.shift_clk <= 1'b1;
    end else if (tick) begin
      case (state_reg)
        uaf_pkg::RX_IDLE: begin
          tick_cnt_reg <= 4'h0;
          bit_cnt_reg  <= 4'h0;
          if (is_shift) begin
            state_reg     <= uaf_pkg::RX_DATA;
            rxo.shift_clk <= 1'b0;
          end else if (!sync_reg) begin
            state_reg <= uaf_pkg::RX_START;
          end
        end
        uaf_pkg::RX_START: begin
          if (tick_cnt_reg == uaf_pkg::OVS_MID) begin
            tick_cnt_reg <= 4'h0;
            state_reg    <= sync_reg ? uaf_pkg::RX_IDLE : uaf_pkg::RX_DATA; // false start
          end else begin
            tick_cnt_reg <= tick_cnt_reg + 4'h1;
          end
        end
        uaf_pkg::RX_DATA: begin
          if (is_shift) begin
            rxo.shift_clk <= ~rxo.shift_clk;
            if (!rxo.shift_clk) begin
              shift_reg   <= {sync_reg, shift_reg[8:1]};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (bit_cnt_reg == nbits - 4'h1) begin
                rxo.data    <= {1'b0, sync_reg, shift_reg[8:2]};
                rxo.stop_ok <= 1'b1;
                rxo.done    <= 1'b1;
                state_reg   <= uaf_pkg::RX_STOP;
              end
            end
          end else if (tick_cnt_reg == uaf_pkg::OVS_LAST) begin
            tick_cnt_reg <= 4'h0;
            shift_reg    <= {sync_reg, shift_reg[8:1]};
            bit_cnt_reg  <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == nbits - 4'h1) state_reg <= uaf_pkg::RX_STOP;
          end else begin
            tick_cnt_reg <= tick_cnt_reg + 4'h1;
          end
        end
        uaf_pkg::RX_STOP: begin
          if (is_shift) begin
            rxo.shift_clk <= 1'b1;      // shift mode waits here until the flag sets and disables it
          end else if (tick_cnt_reg == uaf_pkg::OVS_LAST) begin
            // 8-bit mode carries the stop bit as the ninth bit
            rxo.data    <= (nbits == uaf_pkg::BITS_8) ? {sync_reg, shift_reg[8:1]} : shift_reg;
            rxo.stop_ok <= sync_reg; // R1
            rxo.done    <= 1'b1;
            state_reg   <= uaf_pkg::RX_IDLE;
          end else begin
            tick_cnt_reg <= tick_cnt_reg + 4'h1;
          end
        end
        default: state_reg <= uaf_pkg::RX_IDLE;
      endcase
    end
  end
endmodule

// >>> uaf_serial_rx.sv
// serial receiver top: registers, framing error, address recognition
//
// Operation
// (R1) in modes 1, 2 and 3 each frame is checked for a stop bit and a missing one sets the error.
// (R2) the framing error stays set until software writes it to zero; good frames never clear it.
// (R3) control bit 7 reaches the mode bit when the select bit is 0 and the error when it is 1.
// (R4) with compare enabled in 9-bit modes the flag sets only on a given or broadcast match.
// (R5) address bytes carry a ninth bit of 1 and data bytes a ninth bit of 0.
// (R6) while compare is enabled data bytes never set the flag; clearing it lets them through. Here mode 0 bytes still set it (R8).
// (R7) in mode 1 with compare enabled the flag needs a match and a valid stop bit.
// (R8) in mode 0 the compare enable has no effect on reception.
// (R9) the given address compares only the bits where the mask is one.
// (R10) the broadcast address is address or mask, a byte matching with ones at all its ones.
// (R11) address and mask reset to zero so every address byte matches.
// (R12) the address register sits at A9 and the mask register at B9.
// (R13) in 9-bit modes with compare on, only ninth-bit-one frames are compared, misses dropped.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module uaf_serial_rx (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  // serial pins
  input  wire logic       rx_pin,
  output logic            shift_clk,
  // interrupt
  output logic            irq
);

  //////////////////////////////////////////////////////////////////////////
  // register state

  logic [7:0] serial_control_reg;
  logic       framing_error_flag_reg;
  logic [7:0] power_control_reg;
  logic [7:0] slave_address_reg;
  logic [7:0] slave_address_mask_reg;
  logic [7:0] rx_buffer_reg;
  logic [7:0] baud_div_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  logic [7:0] baud_cnt_reg;
  logic       tick_reg;

  // decoded control
  logic [1:0] mode;
  logic       compare_en;
  logic       rx_enable;
  logic       receive_flag;
  logic       flag_select;

  assign mode         = {serial_control_reg[uaf_pkg::SCTL_MODE0_BIT],
                         serial_control_reg[uaf_pkg::SCTL_MODE1_BIT]};
  assign compare_en   = serial_control_reg[uaf_pkg::SCTL_CMP_BIT];
  assign rx_enable    = serial_control_reg[uaf_pkg::SCTL_REN_BIT];
  assign receive_flag = serial_control_reg[uaf_pkg::SCTL_RI_BIT];
  assign flag_select  = power_control_reg[uaf_pkg::PCTL_FSEL_BIT];

  //////////////////////////////////////////////////////////////////////////
  // access decode

  logic wr_sctl;
  logic wr_pctl;
  logic wr_sadr;
  logic wr_smsk;
  logic wr_imask;
  logic wr_baud;
  logic rd_istat;

  // one decode per register so writes never alias
  assign wr_sctl  = reg_wr && (reg_addr == uaf_pkg::SCTL_OFS);
  assign wr_pctl  = reg_wr && (reg_addr == uaf_pkg::PCTL_OFS);
  assign wr_sadr  = reg_wr && (reg_addr == uaf_pkg::SADR_OFS);   // R12
  assign wr_smsk  = reg_wr && (reg_addr == uaf_pkg::SMSK_OFS);   // R12
  assign wr_imask = reg_wr && (reg_addr == uaf_pkg::IMASK_OFS);
  assign wr_baud  = reg_wr && (reg_addr == uaf_pkg::BAUD_OFS);
  assign rd_istat = reg_rd && (reg_addr == uaf_pkg::ISTAT_OFS);

  //////////////////////////////////////////////////////////////////////////
  // baud tick

  // one tick per baud_div+1 clocks; 16 ticks per bit in modes 1 to 3,
  // two ticks per bit in mode 0; mode 2 shares the divider by design
  always_ff @(posedge core_clk) begin
    if (rst) begin
      baud_cnt_reg <= 8'h00;
      tick_reg     <= 1'b0;
    end else if (baud_cnt_reg >= baud_div_reg) begin
      baud_cnt_reg <= 8'h00;
      tick_reg     <= 1'b1;
    end else begin
      baud_cnt_reg <= baud_cnt_reg + 8'h01;
      tick_reg     <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // deserialiser and matcher

  uaf_rx_if rxi ();

  logic frame_enable;
  logic addr_match;

  // shift mode only runs while the receive flag is clear
  assign frame_enable = rx_enable && (mode != uaf_pkg::MODE_SHIFT || !receive_flag);

  uaf_rx_frame u_frame (
    .core_clk (core_clk),
    .rst      (rst),
    .rx_pin   (rx_pin),
    .tick     (tick_reg),
    .enable   (frame_enable),
    .mode     (mode),
    .rxo      (rxi.frame)
  );

  uaf_addr_match u_match (
    .rx_byte            (rxi.data[7:0]),
    .slave_address      (slave_address_reg),
    .slave_address_mask (slave_address_mask_reg),
    .match              (addr_match)
  );

  //////////////////////////////////////////////////////////////////////////
  // acceptance of a finished frame

  logic accept;
  logic fe_event;

  // decide whether a finished frame loads the buffer and raises the flag
  always_comb begin
    accept = 1'b0;
    if (rxi.done && !receive_flag) begin
      case (mode)
        uaf_pkg::MODE_SHIFT: accept = 1'b1; // R8
        uaf_pkg::MODE_8BIT:  accept = !compare_en || (rxi.stop_ok && addr_match); // R7
        default: begin
          // ninth bit one marks an address byte, zero a data byte
          if (!compare_en) begin
            accept = 1'b1;
          end else begin
            accept = rxi.data[8] && addr_match; // R4 R5 R6 R13
          end
        end
      endcase
    end
  end

  // only asynchronous modes can see a missing stop bit
  assign fe_event = rxi.done && (mode != uaf_pkg::MODE_SHIFT) && !rxi.stop_ok; // R1

  //////////////////////////////////////////////////////////////////////////
  // serial control register

  // software writes land first, hardware set of the flag wins afterwards
  always_ff @(posedge core_clk) begin
    if (rst) begin
      serial_control_reg <= uaf_pkg::SCTL_RST;
    end else begin
      if (wr_sctl) begin
        serial_control_reg[6:0] <= reg_wdata[6:0];
        if (!flag_select) begin
          serial_control_reg[uaf_pkg::SCTL_MODE0_BIT] <= reg_wdata[7]; // R3
        end
      end
      if (accept) begin
        serial_control_reg[uaf_pkg::SCTL_RI_BIT]  <= 1'b1;
        serial_control_reg[uaf_pkg::SCTL_RB8_BIT] <= rxi.data[8];
      end
    end
  end

  // framing error: sticky, software clears by writing zero through bit 7
  always_ff @(posedge core_clk) begin
    if (rst) begin
      framing_error_flag_reg <= 1'b0;
    end else if (fe_event) begin
      framing_error_flag_reg <= 1'b1; // R1 R2
    end else if (wr_sctl && flag_select) begin
      framing_error_flag_reg <= reg_wdata[7]; // R2 R3
    end
  end

  // received byte buffer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_buffer_reg <= 8'h00;
    end else if (accept) begin
      rx_buffer_reg <= rxi.data[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // other software registers

  // power control: only the select bit steers this block
  always_ff @(posedge core_clk) begin
    if (rst) begin
      power_control_reg <= uaf_pkg::PCTL_RST;
    end else if (wr_pctl) begin
      power_control_reg <= reg_wdata;
    end
  end

  // zero after reset means every address byte matches
  always_ff @(posedge core_clk) begin
    if (rst) begin
      slave_address_reg      <= uaf_pkg::SADR_RST; // R11
      slave_address_mask_reg <= uaf_pkg::SMSK_RST; // R11
    end else begin
      if (wr_sadr) slave_address_reg <= reg_wdata;
      if (wr_smsk) slave_address_mask_reg <= reg_wdata;
    end
  end

  // baud divider; a change applies to the count in progress, which wraps at once if already at or past it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      baud_div_reg <= uaf_pkg::BAUD_RST;
    end else if (wr_baud) begin
      baud_div_reg <= reg_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  logic [1:0] irq_events;

  assign irq_events = {fe_event, accept};

  // read clears, but an event in the same cycle survives the clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_status_reg <= uaf_pkg::IRQ_RST;
    end else if (rd_istat) begin
      irq_status_reg <= irq_events;
    end else begin
      irq_status_reg <= irq_status_reg | irq_events;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_mask_reg <= uaf_pkg::IRQ_RST;
    end else if (wr_imask) begin
      irq_mask_reg <= reg_wdata[1:0];
    end
  end

  // level output one clock behind the status bits
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read port

  logic [7:0] sctl_view;

  // bit 7 shows the mode bit or the error depending on the select bit
  assign sctl_view = {flag_select ? framing_error_flag_reg
                                  : serial_control_reg[uaf_pkg::SCTL_MODE0_BIT],
                      serial_control_reg[6:0]}; // R3

  // data valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk) begin
    if (rst || !reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        uaf_pkg::SCTL_OFS:  reg_rdata <= sctl_view;
        uaf_pkg::RBUF_OFS:  reg_rdata <= rx_buffer_reg;
        uaf_pkg::PCTL_OFS:  reg_rdata <= power_control_reg;
        uaf_pkg::SADR_OFS:  reg_rdata <= slave_address_reg;
        uaf_pkg::SMSK_OFS:  reg_rdata <= slave_address_mask_reg;
        uaf_pkg::ISTAT_OFS: reg_rdata <= {6'h00, irq_status_reg};
        uaf_pkg::IMASK_OFS: reg_rdata <= {6'h00, irq_mask_reg};
        uaf_pkg::BAUD_OFS:  reg_rdata <= baud_div_reg;
        default:            reg_rdata <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // shift clock pin

  // re-registered so the pin comes straight from a top-level flop;
  // idles high outside mode 0 reception
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shift_clk <= 1'b1;
    end else begin
      shift_clk <= rxi.shift_clk;
    end
  end

endmodule

// >>> uaf_serial_rx_asserts.sv
// checker: register port and interrupt relations of the serial receiver
`timescale 1ns/1ps
module uaf_serial_rx_chk (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // serial pins and interrupt
  input wire logic       rx_pin,
  input wire logic       shift_clk,
  input wire logic       irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [7:0] sadr_reg, smsk_reg, ctl_reg;
  logic [1:0] imsk_reg;
  logic       fsel_reg, fe_rd_reg, fe_seen_reg, is_ctl, mapped;
  // address decode seen from outside
  assign is_ctl = reg_addr == uaf_pkg::SCTL_OFS;
  assign mapped = is_ctl || reg_addr inside {uaf_pkg::RBUF_OFS, uaf_pkg::PCTL_OFS,
    uaf_pkg::SADR_OFS, uaf_pkg::SMSK_OFS, uaf_pkg::ISTAT_OFS, uaf_pkg::IMASK_OFS,
    uaf_pkg::BAUD_OFS};
  //////////////////////////////////////////////////////////////////
  // shadows of software fields; bit 7 tracks the mode bit only while not redirected
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sadr_reg <= 8'h00;
      smsk_reg <= 8'h00;
      ctl_reg  <= 8'h00;
      imsk_reg <= 2'h0;
      fsel_reg <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == uaf_pkg::SADR_OFS) sadr_reg <= reg_wdata;
      if (reg_addr == uaf_pkg::SMSK_OFS) smsk_reg <= reg_wdata;
      if (reg_addr == uaf_pkg::IMASK_OFS) imsk_reg <= reg_wdata[1:0];
      if (reg_addr == uaf_pkg::PCTL_OFS) fsel_reg <= reg_wdata[uaf_pkg::PCTL_FSEL_BIT];
      if (is_ctl) ctl_reg[6:3] <= reg_wdata[6:3];
      if (is_ctl && !fsel_reg) ctl_reg[7] <= reg_wdata[7];
    end
  end
  // error flag once seen set; only a software clear may take it back
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fe_rd_reg   <= 1'b0;
      fe_seen_reg <= 1'b0;
    end else begin
      fe_rd_reg <= reg_rd && is_ctl && fsel_reg;
      if (reg_wr && is_ctl && fsel_reg && !reg_wdata[7]) fe_seen_reg <= 1'b0;
      else if (fe_rd_reg && reg_rdata[7]) fe_seen_reg <= 1'b1;
    end
  end
  //////////////////////////////////////////////////////////////////
  unmapped_read_a:
    assert property (reg_rd && !mapped |=> reg_rdata == 8'h00) else $error("unmapped read data");
  idle_rdata_a:
    assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("stray read data");
  reset_out_a:
    assert property (disable iff (1'b0) rst |=> reg_rdata == 8'h00 && shift_clk && !irq)
    else $error("outputs not at reset level");
  addr_readback_a:
    assert property (reg_rd && reg_addr == uaf_pkg::SADR_OFS |=> reg_rdata == sadr_reg)
    else $error("address register readback wrong");
  mask_readback_a:
    assert property (reg_rd && reg_addr == uaf_pkg::SMSK_OFS |=> reg_rdata == smsk_reg)
    else $error("mask register readback wrong");
  fe_sticky_a:
    assert property (reg_rd && is_ctl && fsel_reg && fe_seen_reg |=> reg_rdata[7])
    else $error("error flag cleared without software");
  mode_view_a:
    assert property (reg_rd && is_ctl && !fsel_reg |=> reg_rdata[7] == ctl_reg[7])
    else $error("mode bit view wrong");
  select_readback_a:
    assert property (reg_rd && reg_addr == uaf_pkg::PCTL_OFS |=> reg_rdata[6] == fsel_reg)
    else $error("select bit readback wrong");
  ctl_fields_a:
    assert property (reg_rd && is_ctl |=> reg_rdata[6:3] == ctl_reg[6:3])
    else $error("control fields readback wrong");
  irq_masked_a:
    assert property ((imsk_reg == 2'h0) [*3] |-> !irq) else $error("interrupt while masked");
  // main scenarios reached
  irq_seen_c: cover property ($rose(irq));
  fe_seen_c: cover property (fe_rd_reg && reg_rdata[7]);
  shift_c: cover property ($fell(shift_clk));
  start_c: cover property ($fell(rx_pin));
endmodule

bind uaf_serial_rx uaf_serial_rx_chk u_chk (
  .core_clk  (core_clk),
  .rst       (rst),
  .reg_addr  (reg_addr),
  .reg_wdata (reg_wdata),
  .reg_wr    (reg_wr),
  .reg_rd    (reg_rd),
  .reg_rdata (reg_rdata),
  .rx_pin    (rx_pin),
  .shift_clk (shift_clk),
  .irq       (irq)
);

// >>> uaf_line_master.sv
// line model: a master port sending frames on the shared receive line
`timescale 1ns/1ps
module uaf_line_master #(
  parameter int BIT_CLKS = 32
) (
  // clock
  input  wire logic core_clk,
  // serial line
  output logic      line
);
  // idles at the mark level, as the pulled-up line does
  initial line = 1'b1;
  // one bit time, changed just after an edge
  task automatic bit_out(input logic v);
    @(posedge core_clk);
    line <= v;
    repeat (BIT_CLKS - 1) @(posedge core_clk);
  endtask
  // start, data lsb first, ninth bit in 9-bit frames, stop, one idle bit
  task automatic send(input logic [8:0] frm, input logic [3:0] nb, input logic stp);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) bit_out(frm[i]);
    if (nb == 4'h9) bit_out(frm[8]);
    bit_out(stp);
    bit_out(1'b1);
  endtask
  // static level, used as shift-mode data
  task automatic hold(input logic v);
    @(posedge core_clk);
    line <= v;
  endtask
endmodule

// >>> tb_top.sv
// testbench: registers, framing error, address recognition, shift mode, interrupt
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic [7:0] ctl; logic [8:0] frm; logic [3:0] nb;
    logic stp; logic ri;} uaf_case_t;
  logic       core_clk, rst, reg_wr, reg_rd, rx_pin, shift_clk, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  int         error_cnt, checks;
  uaf_case_t  cases [10];
  // device and far-side master; divider 1 gives 32 clocks a bit
  uaf_serial_rx dut (
    .core_clk  (core_clk),
    .rst       (rst),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .rx_pin    (rx_pin),
    .shift_clk (shift_clk),
    .irq       (irq)
  );
  uaf_line_master #(.BIT_CLKS(32)) peer (.core_clk(core_clk), .line(rx_pin));
  always #5 core_clk = ~core_clk;
  //////////////////////////////////////////////////////////////////
  // bus cycles: strobe for one cycle, read data taken in the answer cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0; rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 8'h00; reg_wdata = 8'h00; error_cnt = 0; checks = 0;
    // control, frame, bits, stop level, flag expected; first runs on reset addresses
    cases = '{'{8'hF0, 9'h1A5, 4'h9, 1'b1, 1'b1}, '{8'hF0, 9'h1F0, 4'h9, 1'b1, 1'b1},
      '{8'hF0, 9'h1F3, 4'h9, 1'b1, 1'b0}, '{8'hF0, 9'h1FF, 4'h9, 1'b1, 1'b1},
      '{8'hF0, 9'h0F0, 4'h9, 1'b1, 1'b0}, '{8'hD0, 9'h055, 4'h9, 1'b1, 1'b1},
      '{8'hB0, 9'h1F5, 4'h9, 1'b1, 1'b1}, '{8'h70, 9'h0F0, 4'h8, 1'b0, 1'b0},
      '{8'h70, 9'h0F0, 4'h8, 1'b1, 1'b1}, '{8'h70, 9'h0F3, 4'h8, 1'b1, 1'b0}};
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    rd(uaf_pkg::SADR_OFS, d); chk("address reset", d, 8'h00);
    rd(uaf_pkg::SMSK_OFS, d); chk("mask reset", d, 8'h00);
    rd(8'h10, d); chk("unmapped", d, 8'h00);
    wr(uaf_pkg::BAUD_OFS, 8'h01);
    wr(uaf_pkg::IMASK_OFS, 8'h03);
    // plain 8-bit frame raises the interrupt; reading status drops it
    wr(uaf_pkg::SCTL_OFS, 8'h50);
    peer.send(9'h0A5, 4'h8, 1'b1);
    rd(uaf_pkg::RBUF_OFS, d); chk("rx byte", d, 8'hA5);
    chk("irq raised", {7'h0, irq}, 8'h01);
    rd(uaf_pkg::ISTAT_OFS, d); chk("status", d & 8'h01, 8'h01);
    repeat (3) @(posedge core_clk);
    #1 chk("irq cleared", {7'h0, irq}, 8'h00);
    // missing stop bit, masked; flag sticks through a good frame until written 0
    wr(uaf_pkg::IMASK_OFS, 8'h00);
    wr(uaf_pkg::SCTL_OFS, 8'h50);
    peer.send(9'h03C, 4'h8, 1'b0);
    chk("irq masked", {7'h0, irq}, 8'h00);
    wr(uaf_pkg::PCTL_OFS, 8'h40);
    rd(uaf_pkg::PCTL_OFS, d); chk("select", d & 8'h40, 8'h40);
    rd(uaf_pkg::SCTL_OFS, d); chk("error flag", d & 8'h80, 8'h80);
    wr(uaf_pkg::SCTL_OFS, 8'hD0);
    peer.send(9'h0C3, 4'h8, 1'b1);
    rd(uaf_pkg::SCTL_OFS, d); chk("error kept", d & 8'h81, 8'h81);
    wr(uaf_pkg::SCTL_OFS, 8'h50);
    rd(uaf_pkg::SCTL_OFS, d); chk("error cleared", d & 8'h80, 8'h00);
    wr(uaf_pkg::PCTL_OFS, 8'h00);
    rd(uaf_pkg::SCTL_OFS, d); chk("mode view", d & 8'hF0, 8'h50);
    wr(uaf_pkg::IMASK_OFS, 8'h03);
    repeat (2) @(posedge core_clk);
    #1 chk("irq unmasked", {7'h0, irq}, 8'h01);
    rd(uaf_pkg::ISTAT_OFS, d); chk("status both", d & 8'h03, 8'h03);
    // address recognition across modes 1, 2 and 3
    for (int i = 0; i < 10; i++) begin
      if (i == 1) begin
        wr(uaf_pkg::SADR_OFS, 8'hF1);
        wr(uaf_pkg::SMSK_OFS, 8'hFA);
        rd(uaf_pkg::SADR_OFS, d); chk("address reg", d, 8'hF1);
        rd(uaf_pkg::SMSK_OFS, d); chk("mask reg", d, 8'hFA);
      end
      wr(uaf_pkg::SCTL_OFS, cases[i].ctl);
      peer.send(cases[i].frm, cases[i].nb, cases[i].stp);
      rd(uaf_pkg::SCTL_OFS, d);
      chk("receive flag", {7'h0, d[0]}, {7'h0, cases[i].ri});
      if (cases[i].ri && cases[i].nb == 4'h9) begin
        chk("ninth bit", {7'h0, d[2]}, {7'h0, cases[i].frm[8]});
      end
      if (cases[i].ri) begin
        rd(uaf_pkg::RBUF_OFS, d); chk("rx byte", d, cases[i].frm[7:0]);
      end
    end
    // shift mode with compare enable set still receives
    peer.hold(1'b0);
    wr(uaf_pkg::SCTL_OFS, 8'h30);
    d = 8'h00;
    for (int n = 0; n < 400 && d[0] !== 1'b1; n++) rd(uaf_pkg::SCTL_OFS, d);
    // a poll that runs out shows up here as a mismatch
    chk("shift flag", {7'h0, d[0]}, 8'h01);
    if (d[0] === 1'b1) begin
      rd(uaf_pkg::RBUF_OFS, d); chk("shift byte", d, 8'h00);
    end
    give_verdict();
  end
endmodule
